// [logic/ptm_pkg.sv]
// Shared widths, encodings and carriers of the table move and search engine
package ptm_pkg;

  // Word and field widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int LEN_W = 8;

  // Pointer values and step sizes
  localparam logic [DATA_W-1:0] PTR_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] PTR_RELOAD = 16'h0001;
  localparam logic [DATA_W-1:0] PTR_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] FIRST_DATA_IDX = 16'h0001;

  // Accumulator answer when the search fails
  localparam logic [DATA_W-1:0] ACC_NOT_FOUND = 16'h0000;

  // Depth of the write buffer
  localparam int WBUF_DEPTH = 2;

  // Values after reset
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [LEN_W-1:0] RST_IDX = 8'h00;

  // Table instructions
  typedef enum logic [1:0] {
    PTM_FIND_GREATER_OP = 2'b00,
    PTM_TABLE_TO_DEST_OP = 2'b01,
    PTM_REMOVE_BOTTOM_OP = 2'b10
  } ptm_op_t;

  // One instruction as the scan logic issues it
  typedef struct packed {
    ptm_op_t op;                  // Which instruction
    logic rung_en;                // Enabling input condition of the rung
    logic [ADDR_W-1:0] start_addr; // Accumulator: table start address
    logic [LEN_W-1:0] tbl_len;    // First stack level: table length
    logic [DATA_W-1:0] search_val; // Value for the greater-than search
    logic [ADDR_W-1:0] dest_addr; // Destination word address
  } ptm_cmd_t;

  // One data memory write
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ptm_wr_t;

endpackage

// [logic/ptm_ptr_step.sv]
`timescale 1ns/10ps
`default_nettype none
// Pointer arithmetic of the two pointer-based instructions
module ptm_ptr_step (
  // Operation and operands
  input wire ptm_pkg::ptm_op_t op_i,
  input wire logic [ptm_pkg::DATA_W-1:0] ptr_i,
  input wire logic [ptm_pkg::LEN_W-1:0] len_i,
  // Results
  output logic move_o,
  output logic [ptm_pkg::ADDR_W-1:0] data_idx_o,
  output logic [ptm_pkg::DATA_W-1:0] next_ptr_o,
  output logic flag_o
);

  logic [ptm_pkg::DATA_W-1:0] len_w; // Length at word width
  logic in_range; // Pointer lies inside the table

  assign len_w = {{(ptm_pkg::DATA_W-ptm_pkg::LEN_W){1'b0}}, len_i};
  assign in_range = (ptr_i <= len_w);

  // Index, next pointer and flag per instruction
  always_comb begin
    move_o = 1'b0;
    data_idx_o = ptm_pkg::FIRST_DATA_IDX;
    next_ptr_o = ptr_i;
    flag_o = 1'b0;
    if (op_i == ptm_pkg::PTM_TABLE_TO_DEST_OP) begin
      // Out-of-range pointer moves nothing
      move_o = in_range;
      if (in_range) begin
        // Zero and full length both pick the first data word
        if ((ptr_i == ptm_pkg::PTR_ZERO) || (ptr_i == len_w)) begin
          data_idx_o = ptm_pkg::FIRST_DATA_IDX;
        end else begin
          data_idx_o = ptr_i + ptm_pkg::PTR_STEP;
        end
        // Wrap to one at the last location, else count up
        next_ptr_o = (ptr_i == len_w) ? ptm_pkg::PTR_RELOAD : ptr_i + ptm_pkg::PTR_STEP;
        flag_o = (next_ptr_o == len_w);
      end
    end else if (op_i == ptm_pkg::PTM_REMOVE_BOTTOM_OP) begin
      // Nothing moves once the pointer is zero
      move_o = (ptr_i != ptm_pkg::PTR_ZERO) && in_range;
      data_idx_o = ptr_i;
      next_ptr_o = move_o ? ptr_i - ptm_pkg::PTR_STEP : ptr_i;
      flag_o = (next_ptr_o == ptm_pkg::PTR_ZERO);
    end
  end

endmodule
`default_nettype wire

// [logic/ptm_word_buf.sv]
`timescale 1ns/10ps
`default_nettype none
// Small ring buffer between the engine and the memory write port
module ptm_word_buf #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // All state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // Entries
    logic [PW-1:0] wr_ptr; // Next slot to fill
    logic [PW-1:0] rd_ptr; // Oldest slot
    logic [CW-1:0] count; // Words held
  } ptm_buf_st_t;

  ptm_buf_st_t r;
  ptm_buf_st_t next_r;
  logic push; // Word taken this cycle
  logic pop; // Word handed on this cycle

  // Honest full and empty, both held low while the enable is low
  assign in_ready_o = clk_en_i && (r.count != CW'(DEPTH));
  assign out_valid_o = clk_en_i && (r.count != '0);
  assign out_data_o = r.mem[r.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr_ptr] = in_data_i;
      next_r.wr_ptr = (r.wr_ptr == PW'(DEPTH - 1)) ? '0 : r.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_r.rd_ptr = (r.rd_ptr == PW'(DEPTH - 1)) ? '0 : r.rd_ptr + 1'b1;
    end
    // Count moves only when exactly one side acts
    if (push && !pop) begin
      next_r.count = r.count + 1'b1;
    end else if (pop && !push) begin
      next_r.count = r.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

// [logic/ptm_table_engine.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Found word's offset goes to accumulator
// - No match: accumulator zero, failure flag set
// - Flags hold until reused or scan end
// - Pointer plus one, then copy the word it now points at
// - First word is pointer, data follows
// - Runs once per scan while enabled
// - Pointer at last location reloads one
// - Pointer zero selects first data word
// - Pointer flag when pointer equals length
// - Copy pointed word, then pointer minus one
// - No move once pointer reaches zero
// - Pointer flag when pointer is zero
// - Pointer n selects n-th data word
module ptm_table_engine (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Instruction port, one per rung evaluation
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire ptm_pkg::ptm_cmd_t cmd_i,
  // Scan boundary, one-cycle pulse
  input wire logic scan_end_i,
  // Data memory read
  output logic mem_rd_req_o,
  output logic [ptm_pkg::ADDR_W-1:0] mem_rd_addr_o,
  input wire logic mem_rd_valid_i,
  input wire logic [ptm_pkg::DATA_W-1:0] mem_rd_data_i,
  // Data memory write
  output logic mem_wr_valid_o,
  input wire logic mem_wr_ready_i,
  output ptm_pkg::ptm_wr_t mem_wr_o,
  // Results
  output logic done_o,
  output logic acc_valid_o,
  output logic [ptm_pkg::DATA_W-1:0] acc_o,
  output logic search_fail_flag_o,
  output logic table_pointer_flag_o
);

  // Pointer ops: pointer read, then data read and two writes only if the pointer moves
  // Search: one read and one compare per table word
  // Engine states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_PTR_REQ = 4'h1,
    S_PTR_WAIT = 4'h2,
    S_DATA_REQ = 4'h3,
    S_DATA_WAIT = 4'h4,
    S_PUSH_DEST = 4'h5,
    S_PUSH_PTR = 4'h6,
    S_SRCH_REQ = 4'h7,
    S_SRCH_WAIT = 4'h8
  } ptm_state_t;

  // All state of the engine
  typedef struct packed {
    ptm_state_t state;
    ptm_pkg::ptm_cmd_t cmd; // Instruction being run
    logic [ptm_pkg::DATA_W-1:0] ptr; // Pointer word as read
    logic [ptm_pkg::DATA_W-1:0] word; // Table word fetched
    logic [ptm_pkg::LEN_W-1:0] idx; // Search offset
    logic [ptm_pkg::DATA_W-1:0] acc; // Accumulator answer
    logic acc_valid; // Answer pulse
    logic done; // Completion pulse
    logic fail_flag; // Search failure flag
    logic ptr_flag; // Table pointer flag
  } ptm_eng_st_t;

  ptm_eng_st_t r;
  ptm_eng_st_t next_r;

  localparam logic [ptm_pkg::LEN_W-1:0] RST_LEN = 8'h00; // Empty table length

  // Pointer step results
  logic step_move;
  logic [ptm_pkg::ADDR_W-1:0] step_idx;
  logic [ptm_pkg::DATA_W-1:0] step_next_ptr;
  logic step_flag;

  // Write buffer filling side
  logic wbuf_valid;
  logic wbuf_ready;
  ptm_pkg::ptm_wr_t wbuf_data;
  ptm_pkg::ptm_wr_t wbuf_out;
  logic [ptm_pkg::LEN_W-1:0] last_idx; // Final search offset

  // Offset of the final word; an empty table never searches
  assign last_idx = r.cmd.tbl_len - 8'h01;

  // Pointer arithmetic for the running instruction
  ptm_ptr_step u_step (
    .op_i(r.cmd.op),
    .ptr_i(r.ptr),
    .len_i(r.cmd.tbl_len),
    .move_o(step_move),
    .data_idx_o(step_idx),
    .next_ptr_o(step_next_ptr),
    .flag_o(step_flag)
  );

  // Two-entry buffer so a stalled memory loses no write
  ptm_word_buf #(
    .W($bits(ptm_pkg::ptm_wr_t)),
    .DEPTH(ptm_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(wbuf_valid),
    .in_ready_o(wbuf_ready),
    .in_data_i(wbuf_data),
    .out_valid_o(mem_wr_valid_o),
    .out_ready_i(mem_wr_ready_i),
    .out_data_o(wbuf_out)
  );

  // Write port comes straight from the buffer register
  assign mem_wr_o = wbuf_out;

  // Handshakes out of the current state
  // Ready only in idle, never while frozen
  assign cmd_ready_o = clk_en_i && (r.state == S_IDLE);
  always_comb begin
    mem_rd_req_o = 1'b0;
    mem_rd_addr_o = r.cmd.start_addr;
    wbuf_valid = 1'b0;
    wbuf_data = '0;
    unique case (r.state)
      // Pointer word sits at the table start
      S_PTR_REQ: begin
        mem_rd_req_o = clk_en_i;
      end
      // Data word behind the pointer word
      S_DATA_REQ: begin
        mem_rd_req_o = clk_en_i && step_move;
        mem_rd_addr_o = r.cmd.start_addr + step_idx;
      end
      // Search walks from the table start upward
      S_SRCH_REQ: begin
        mem_rd_req_o = clk_en_i;
        mem_rd_addr_o = r.cmd.start_addr + {8'h00, r.idx};
      end
      // Copy the word to its destination
      S_PUSH_DEST: begin
        wbuf_valid = 1'b1;
        wbuf_data.addr = r.cmd.dest_addr;
        wbuf_data.data = r.word;
      end
      // Then store the stepped pointer
      S_PUSH_PTR: begin
        wbuf_valid = 1'b1;
        wbuf_data.addr = r.cmd.start_addr;
        wbuf_data.data = step_next_ptr;
      end
      // Idle and wait states issue nothing
      default: begin
        mem_rd_req_o = 1'b0;
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.acc_valid = 1'b0;
    // Flags drop at scan end; a set below overrides
    if (scan_end_i) begin
      next_r.fail_flag = 1'b0;
      next_r.ptr_flag = 1'b0;
    end
    unique case (r.state)
      // Accept one instruction
      S_IDLE: begin
        if (cmd_valid_i) begin
          next_r.cmd = cmd_i;
          next_r.idx = ptm_pkg::RST_IDX;
          if (!cmd_i.rung_en) begin
            // Rung false: nothing executes this scan
            next_r.done = 1'b1;
          end else if (cmd_i.op == ptm_pkg::PTM_FIND_GREATER_OP) begin
            if (cmd_i.tbl_len == RST_LEN) begin
              // Empty table finds nothing
              next_r.acc = ptm_pkg::ACC_NOT_FOUND;
              next_r.fail_flag = 1'b1;
              next_r.acc_valid = 1'b1;
              next_r.done = 1'b1;
            end else begin
              next_r.state = S_SRCH_REQ;
            end
          end else begin
            // One execution per issued instruction
            next_r.state = S_PTR_REQ;
          end
        end
      end
      // Pointer read issued, wait for its answer
      S_PTR_REQ: begin
        next_r.state = S_PTR_WAIT;
      end
      // Latch the pointer word
      S_PTR_WAIT: begin
        if (mem_rd_valid_i) begin
          // Pointer as it stands in memory
          next_r.ptr = mem_rd_data_i;
          next_r.state = S_DATA_REQ;
        end
      end
      // Pointer outside the table, or at zero for remove from bottom, moves nothing
      S_DATA_REQ: begin
        if (step_move) begin
          next_r.state = S_DATA_WAIT;
        end else begin
          // Nothing to copy; report the flag and finish
          next_r.ptr_flag = step_flag;
          next_r.done = 1'b1;
          next_r.state = S_IDLE;
        end
      end
      S_DATA_WAIT: begin
        if (mem_rd_valid_i) begin
          // Table word to be copied
          next_r.word = mem_rd_data_i;
          next_r.state = S_PUSH_DEST;
        end
      end
      // Wait for room in the write buffer
      S_PUSH_DEST: begin
        if (wbuf_ready) begin
          next_r.state = S_PUSH_PTR;
        end
      end
      // Pointer stored, flag from the new pointer
      S_PUSH_PTR: begin
        if (wbuf_ready) begin
          next_r.ptr_flag = step_flag;
          next_r.done = 1'b1;
          next_r.state = S_IDLE;
        end
      end
      // One read per compared word
      S_SRCH_REQ: begin
        next_r.state = S_SRCH_WAIT;
      end
      // Compare one table word, strictly greater wins
      S_SRCH_WAIT: begin
        if (mem_rd_valid_i) begin
          if (mem_rd_data_i > r.cmd.search_val) begin
            // Offset of the hit becomes the answer
            next_r.acc = {8'h00, r.idx};
            next_r.fail_flag = 1'b0;
            next_r.acc_valid = 1'b1;
            next_r.done = 1'b1;
            next_r.state = S_IDLE;
          end else if (r.idx == last_idx) begin
            // Last word compared without a hit
            next_r.acc = ptm_pkg::ACC_NOT_FOUND;
            next_r.fail_flag = 1'b1;
            next_r.acc_valid = 1'b1;
            next_r.done = 1'b1;
            next_r.state = S_IDLE;
          end else begin
            // Move on to the next word
            next_r.idx = r.idx + 8'h01;
            next_r.state = S_SRCH_REQ;
          end
        end
      end
      // Illegal code falls back to idle
      default: begin
        next_r.state = S_IDLE;
      end
    endcase
  end

  // State register
  // Whole state frozen while the enable is low
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // Registered results
  // Accumulator and flags stand until rewritten
  assign done_o = r.done;
  assign acc_valid_o = r.acc_valid;
  assign acc_o = r.acc;
  assign search_fail_flag_o = r.fail_flag;
  assign table_pointer_flag_o = r.ptr_flag;

endmodule
`default_nettype wire

// [testbench/ptm_table_engine_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the table move and search engine
module ptm_table_engine_sva (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // Instruction port and scan boundary
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire ptm_pkg::ptm_cmd_t cmd_i,
  input wire logic scan_end_i,
  // Memory read side
  input wire logic mem_rd_req_o,
  input wire logic [ptm_pkg::ADDR_W-1:0] mem_rd_addr_o,
  input wire logic mem_rd_valid_i,
  input wire logic [ptm_pkg::DATA_W-1:0] mem_rd_data_i,
  // Memory write side
  input wire logic mem_wr_valid_o,
  input wire logic mem_wr_ready_i,
  input wire ptm_pkg::ptm_wr_t mem_wr_o,
  // Results
  input wire logic done_o,
  input wire logic acc_valid_o,
  input wire logic [ptm_pkg::DATA_W-1:0] acc_o,
  input wire logic search_fail_flag_o,
  input wire logic table_pointer_flag_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // Instruction taken at this edge
  logic take;
  assign take = cmd_valid_i && cmd_ready_o;

  // Copy of the running instruction, for range checks
  logic [15:0] cap_start;
  logic [7:0] cap_len;
  ptm_pkg::ptm_op_t cap_op;

  // Latch the operands when an instruction is taken
  always_ff @(posedge sys_clk_i) begin
    if (take) begin
      cap_start <= cmd_i.start_addr;
      cap_len <= cmd_i.tbl_len;
      cap_op <= cmd_i.op;
    end
  end

  rd_range_a: assert property (mem_rd_req_o |-> mem_rd_addr_o >= cap_start &&
    mem_rd_addr_o <= cap_start + 16'(cap_len)) else $error("read outside table");
  rd_single_a: assert property (mem_rd_req_o |=> !mem_rd_req_o)
    else $error("second read while one is open");
  ptr_wrap_a: assert property (mem_wr_valid_o && cap_op == ptm_pkg::PTM_TABLE_TO_DEST_OP &&
    mem_wr_o.addr == cap_start |-> mem_wr_o.data != ptm_pkg::PTR_ZERO && mem_wr_o.data <= 16'(cap_len))
    else $error("forward pointer written out of range");
  idle_rung_a: assert property (take && !cmd_i.rung_en |-> ##[1:2] done_o)
    else $error("disabled rung not finished promptly");
  idle_quiet_a: assert property (take && !cmd_i.rung_en |=> !mem_rd_req_o [*2])
    else $error("disabled rung touched memory");
  empty_find_a: assert property (take && cmd_i.rung_en && cmd_i.op == ptm_pkg::PTM_FIND_GREATER_OP &&
    cmd_i.tbl_len == 8'h00 |-> ##[1:2] (done_o && search_fail_flag_o && acc_o == ptm_pkg::ACC_NOT_FOUND))
    else $error("empty search not reported as failed");
  fail_acc_a: assert property (search_fail_flag_o |-> acc_o == ptm_pkg::ACC_NOT_FOUND)
    else $error("failure flag with nonzero accumulator");
  scan_clr_a: assert property (scan_end_i |=> (!search_fail_flag_o && !table_pointer_flag_o) || done_o)
    else $error("flag survived scan end");
  flag_hold_a: assert property (!$stable(search_fail_flag_o) || !$stable(table_pointer_flag_o)
    |-> done_o || $past(scan_end_i)) else $error("flag changed without cause");
  wr_hold_a: assert property (mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_o))
    else $error("write dropped during stall");

  // Main scenarios reached
  cover property (take && cmd_i.op == ptm_pkg::PTM_REMOVE_BOTTOM_OP);
  cover property ($rose(table_pointer_flag_o));
  cover property (mem_wr_valid_o && !mem_wr_ready_i);
endmodule

bind ptm_table_engine ptm_table_engine_sva u_sva (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .scan_end_i(scan_end_i),
  .mem_rd_req_o(mem_rd_req_o), .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_valid_i(mem_rd_valid_i),
  .mem_rd_data_i(mem_rd_data_i), .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
  .mem_wr_o(mem_wr_o), .done_o(done_o), .acc_valid_o(acc_valid_o), .acc_o(acc_o),
  .search_fail_flag_o(search_fail_flag_o), .table_pointer_flag_o(table_pointer_flag_o)
);
`default_nettype wire

// [testbench/ptm_testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Stimulus, all driven 1 ns after the rising edge
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  ptm_pkg::ptm_cmd_t cmd_i = '0;
  logic scan_end_i = 1'b0;
  logic mem_rd_valid_i = 1'b0;
  logic [15:0] mem_rd_data_i = 16'h0000;
  logic mem_wr_ready_i = 1'b1;
  // Design outputs
  logic cmd_ready_o, mem_rd_req_o, mem_wr_valid_o, done_o, acc_valid_o;
  logic search_fail_flag_o, table_pointer_flag_o;
  logic [15:0] mem_rd_addr_o, acc_o;
  ptm_pkg::ptm_wr_t mem_wr_o;
  // Data memory and its sampled requests
  logic [15:0] mem [0:255];
  logic rq, wv;
  logic [7:0] ra;
  ptm_pkg::ptm_wr_t wd;
  // Write stall pattern
  logic stall = 1'b0;
  logic [1:0] scnt = 2'h0;
  int err_count = 0;
  int total_checks = 0;

  // 125 MHz clock
  always #4 sys_clk_i = ~sys_clk_i;

  ptm_table_engine u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .scan_end_i(scan_end_i),
    .mem_rd_req_o(mem_rd_req_o), .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_valid_i(mem_rd_valid_i),
    .mem_rd_data_i(mem_rd_data_i), .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_ready_i(mem_wr_ready_i),
    .mem_wr_o(mem_wr_o), .done_o(done_o), .acc_valid_o(acc_valid_o), .acc_o(acc_o),
    .search_fail_flag_o(search_fail_flag_o), .table_pointer_flag_o(table_pointer_flag_o)
  );

  // Memory: answers a read one cycle later, idle data keeps flipping
  always @(posedge sys_clk_i) begin
    rq = mem_rd_req_o;
    ra = mem_rd_addr_o[7:0];
    wv = mem_wr_valid_o && mem_wr_ready_i;
    wd = mem_wr_o;
    #1;
    if (wv) begin
      mem[wd.addr[7:0]] = wd.data;
    end
    mem_rd_valid_i = rq;
    mem_rd_data_i = rq ? mem[ra] : ~mem_rd_data_i;
    scnt = scnt + 2'h1;
    // Stalling: accept one write in four
    mem_wr_ready_i = !stall || (scnt == 2'h3);
  end

  // Compare and count
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Issue one instruction, wait for done and for the writes to drain
  task run(input ptm_pkg::ptm_op_t op, input logic en, input logic [15:0] start, input logic [7:0] len,
           input logic [15:0] sv, input logic [15:0] dest);
    int i;
    cmd_i = '{op: op, rung_en: en, start_addr: start, tbl_len: len, search_val: sv, dest_addr: dest};
    cmd_valid_i = 1'b1;
    // Ready is settled between edges, so the next edge takes the instruction
    for (i = 0; i < 50 && cmd_ready_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk("cmd ready", 16'h0001, 16'(cmd_ready_o));
    @(posedge sys_clk_i);
    #1 cmd_valid_i = 1'b0;
    for (i = 0; i < 200 && done_o !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk("done", 16'h0001, 16'(done_o));
    chk("acc valid", 16'(op == ptm_pkg::PTM_FIND_GREATER_OP && en), 16'(acc_valid_o));
    for (i = 0; i < 40 && mem_wr_valid_o !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    // One more edge so the last write has landed in memory
    @(posedge sys_clk_i);
    #1;
  endtask

  // One-cycle scan end pulse
  task scan;
    scan_end_i = 1'b1;
    @(posedge sys_clk_i);
    #1 scan_end_i = 1'b0;
  endtask

  // Greater-than search: hit, miss, first word, empty table
  task t_find;
    mem[8'h10] = 16'h0005;
    mem[8'h11] = 16'h0009;
    mem[8'h12] = 16'h0003;
    mem[8'h13] = 16'h000c;
    run(ptm_pkg::PTM_FIND_GREATER_OP, 1'b1, 16'h0010, 8'h04, 16'h0008, 16'h0000);
    chk("acc", 16'h0001, acc_o);
    chk("fail flag", 16'h0000, 16'(search_fail_flag_o));
    run(ptm_pkg::PTM_FIND_GREATER_OP, 1'b1, 16'h0010, 8'h04, 16'h000c, 16'h0000);
    chk("acc", 16'h0000, acc_o);
    chk("fail flag", 16'h0001, 16'(search_fail_flag_o));
    scan();
    chk("fail flag", 16'h0000, 16'(search_fail_flag_o));
    run(ptm_pkg::PTM_FIND_GREATER_OP, 1'b1, 16'h0010, 8'h04, 16'h0004, 16'h0000);
    chk("acc", 16'h0000, acc_o);
    chk("fail flag", 16'h0000, 16'(search_fail_flag_o));
    run(ptm_pkg::PTM_FIND_GREATER_OP, 1'b1, 16'h0010, 8'h00, 16'h0000, 16'h0000);
    chk("acc", 16'h0000, acc_o);
    chk("fail flag", 16'h0001, 16'(search_fail_flag_o));
    // A later search rewrites the flag before any scan end
    run(ptm_pkg::PTM_FIND_GREATER_OP, 1'b1, 16'h0010, 8'h04, 16'h0008, 16'h0000);
    chk("acc", 16'h0001, acc_o);
    chk("fail flag", 16'h0000, 16'(search_fail_flag_o));
  endtask

  // Table to destination across the wrap, with write stalls
  task t_ttd;
    logic [15:0] p, idx, nx;
    stall = 1'b1;
    mem[8'h20] = 16'h0000;
    for (int k = 1; k <= 3; k++) begin
      mem[8'h20 + k] = 16'h00a0 + 16'(k);
    end
    p = 16'h0000;
    repeat (5) begin
      idx = (p == 16'h0003) ? 16'h0001 : p + 16'h0001;
      nx = idx;
      run(ptm_pkg::PTM_TABLE_TO_DEST_OP, 1'b1, 16'h0020, 8'h03, 16'h0000, 16'h0030);
      chk("dest", 16'h00a0 + idx, mem[8'h30]);
      chk("pointer", nx, mem[8'h20]);
      chk("ptr flag", 16'(nx == 16'h0003), 16'(table_pointer_flag_o));
      if (nx == 16'h0003) begin
        scan();
        chk("ptr flag", 16'h0000, 16'(table_pointer_flag_o));
      end
      p = nx;
    end
    stall = 1'b0;
  endtask

  // Remove from bottom from a preset pointer down to zero, then once more at zero
  task t_rfb;
    logic [15:0] p, nx;
    for (int k = 1; k <= 4; k++) begin
      mem[8'h40 + k] = 16'h00b0 + 16'(k);
    end
    mem[8'h40] = 16'h0003;
    p = 16'h0003;
    repeat (4) begin
      mem[8'h50] = 16'hdead;
      nx = (p == 16'h0000) ? 16'h0000 : p - 16'h0001;
      run(ptm_pkg::PTM_REMOVE_BOTTOM_OP, 1'b1, 16'h0040, 8'h04, 16'h0000, 16'h0050);
      chk("dest", (p == 16'h0000) ? 16'hdead : 16'h00b0 + p, mem[8'h50]);
      chk("pointer", nx, mem[8'h40]);
      chk("ptr flag", 16'(nx == 16'h0000), 16'(table_pointer_flag_o));
      p = nx;
    end
  endtask

  // Disabled rung moves nothing, enabled rung moves once
  task t_idle;
    mem[8'h20] = 16'h0001;
    mem[8'h30] = 16'hbeef;
    run(ptm_pkg::PTM_TABLE_TO_DEST_OP, 1'b0, 16'h0020, 8'h03, 16'h0000, 16'h0030);
    chk("pointer", 16'h0001, mem[8'h20]);
    chk("dest", 16'hbeef, mem[8'h30]);
    run(ptm_pkg::PTM_TABLE_TO_DEST_OP, 1'b1, 16'h0020, 8'h03, 16'h0000, 16'h0030);
    chk("pointer", 16'h0002, mem[8'h20]);
    chk("dest", 16'h00a2, mem[8'h30]);
  endtask

  // Verdict and end of run
  task summarize;
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    t_find();
    t_ttd();
    t_rfb();
    t_idle();
    summarize();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
